/* verilog/srsc_top.sv */
`timescale 1ns/1ps
module srsc_top
(
    input  wire logic       clock,
    input  wire logic       rstn,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr_en,
    input  wire logic       rd_en,
    output logic      [7:0] rdata,
    input  wire logic       reset_pin_n,
    input  wire logic       wdt_reset,
    input  wire logic [6:0] supply_below,
    input  wire logic       irq_any,
    input  wire logic       ext_irq_a,
    input  wire logic       ext_irq_b,
    input  wire logic       ext_irq_c,
    input  wire logic       ext_irq_e,
    input  wire logic       port0_irq,
    input  wire logic       bt_irq,
    input  wire logic       ceramic_req,
    input  wire logic       mrc_req,
    input  wire logic       xtal_req,
    input  wire logic       lsrc_wdt_req,
    output logic            sys_reset_n,
    output logic            core_run,
    output logic            periph_clk_en,
    output logic            bt_clk_en,
    output logic            ceramic_osc_en,
    output logic            mrc_osc_en,
    output logic            xtal_osc_en,
    output logic            lsrc_osc_en
);
    import srsc_pkg::*;

    srsc_state_e           state_r;
    srsc_state_e           state_nxt;
    logic [SRSC_CNT_W-1:0] cnt_r;
    logic [SRSC_CNT_W-1:0] cnt_nxt;
    logic                  xtal_hold_r;
    logic                  xtal_hold_nxt;
    logic                  lsrc_hold_r;
    logic                  lsrc_hold_nxt;
    logic [3:0]            cfg_r;
    logic [3:0]            cfg_nxt;
    logic [3:0]            opt_r;
    logic [3:0]            opt_nxt;
    logic [3:0]            cause_r;
    logic [3:0]            cause_nxt;
    logic [7:0]            rdata_r;
    logic [7:0]            rdata_nxt;
    logic                  por_active;
    logic                  wake_deep;
    logic                  wake_time;
    logic                  lvr_trip;
    logic                  reset_src;
    logic [1:0]            bt_src;
    logic                  bt_on_osc;
    logic [2:0]            lvl;

    // Status nibble for the state; enum order is not exposed to software.
    function automatic logic [3:0] state_bits(input srsc_state_e s);
        logic [3:0] b;
        b = 4'h0;
        case (s)
            SRSC_ST_PAUSE: b[SRSC_ST_PAUSE_BIT] = 1'b1;
            SRSC_ST_DSTOP: b[SRSC_ST_DSTOP_BIT] = 1'b1;
            SRSC_ST_TSTOP: b[SRSC_ST_TSTOP_BIT] = 1'b1;
            SRSC_ST_WAKE:  b[SRSC_ST_WAKE_BIT]  = 1'b1;
            default:       b = 4'h0;
        endcase
        return b;
    endfunction

    srsc_por u_por
    (
        .clock      (clock),
        .rstn       (rstn),
        .por_active (por_active)
    );

    srsc_wake u_wake
    (
        .ext_irq_a       (ext_irq_a),
        .ext_irq_b       (ext_irq_b),
        .ext_irq_c       (ext_irq_c),
        .ext_irq_e       (ext_irq_e),
        .ext_irq_a_level (cfg_r[SRSC_CFG_A_LVL_BIT]),
        .ext_irq_b_level (cfg_r[SRSC_CFG_B_LVL_BIT]),
        .port0_irq       (port0_irq),
        .bt_irq          (bt_irq),
        .wake_deep       (wake_deep),
        .wake_time       (wake_time)
    );

    assign bt_src    = cfg_r[SRSC_CFG_BTSRC_LSB +: 2];
    assign bt_on_osc = (bt_src == SRSC_BT_XTAL) || (bt_src == SRSC_BT_LSRC);
    assign lvl       = opt_r[SRSC_OPT_LVL_LSB +: 3];

    // A level code of seven has no threshold and never trips.
    assign lvr_trip  = opt_r[SRSC_OPT_EN_BIT]
                    && (lvl < 3'(SRSC_LVL_COUNT))
                    && supply_below[lvl];
    assign reset_src = !reset_pin_n || wdt_reset || lvr_trip
                    || por_active;

    // Sequencer.
    always_comb
    begin
        state_nxt     = state_r;
        cnt_nxt       = cnt_r;
        xtal_hold_nxt = xtal_hold_r;
        lsrc_hold_nxt = lsrc_hold_r;
        if (reset_src)
        begin
            state_nxt = SRSC_ST_RESET;
            cnt_nxt   = SRSC_CNT_W'(SRSC_RST_CYCLES - 1);
        end
        else
        begin
            case (state_r)
                SRSC_ST_RUN:
                begin
                    if (wr_en && addr == SRSC_CTRL_OFF)
                    begin
                        case (wdata[SRSC_CTRL_CMD_LSB +: 2])
                            SRSC_CMD_PAUSE: state_nxt = SRSC_ST_PAUSE;
                            SRSC_CMD_DSTOP: state_nxt = SRSC_ST_DSTOP;
                            SRSC_CMD_TSTOP:
                            begin
                                state_nxt     = SRSC_ST_TSTOP;
                                xtal_hold_nxt = xtal_req;
                                lsrc_hold_nxt = lsrc_wdt_req;
                            end
                            default: state_nxt = SRSC_ST_RUN;
                        endcase
                    end
                end
                SRSC_ST_PAUSE:
                begin
                    // Nothing was stopped, so no restart wait is needed.
                    if (irq_any)
                        state_nxt = SRSC_ST_RUN;
                end
                SRSC_ST_DSTOP:
                begin
                    if (wake_deep)
                    begin
                        state_nxt = SRSC_ST_WAKE;
                        cnt_nxt   = SRSC_CNT_W'(SRSC_WAKE_CYCLES - 1);
                    end
                end
                SRSC_ST_TSTOP:
                begin
                    if (wake_time)
                    begin
                        state_nxt = SRSC_ST_WAKE;
                        cnt_nxt   = SRSC_CNT_W'(SRSC_WAKE_CYCLES - 1);
                    end
                end
                SRSC_ST_WAKE:
                begin
                    if (cnt_r == '0)
                        state_nxt = SRSC_ST_RUN;
                    else
                        cnt_nxt = cnt_r - SRSC_CNT_W'(1);
                end
                SRSC_ST_RESET:
                begin
                    if (cnt_r == '0)
                        state_nxt = SRSC_ST_RUN;
                    else
                        cnt_nxt = cnt_r - SRSC_CNT_W'(1);
                end
                default: state_nxt = SRSC_ST_RESET;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            state_r     <= SRSC_ST_RESET;
            cnt_r       <= '0;
            xtal_hold_r <= 1'b0;
            lsrc_hold_r <= 1'b0;
        end
        else
        begin
            state_r     <= state_nxt;
            cnt_r       <= cnt_nxt;
            xtal_hold_r <= xtal_hold_nxt;
            lsrc_hold_r <= lsrc_hold_nxt;
        end
    end

    // Registers. Cause bits are set by hardware over a software clear.
    always_comb
    begin
        cfg_nxt   = cfg_r;
        opt_nxt   = opt_r;
        cause_nxt = cause_r;
        rdata_nxt = 8'h00;
        if (wr_en && addr == SRSC_CFG_OFF)
            cfg_nxt = wdata[3:0];
        else if (wr_en && addr == SRSC_OPT_OFF)
            opt_nxt = wdata[3:0];
        else if (wr_en && addr == SRSC_STATUS_OFF)
            cause_nxt = cause_r & ~wdata[SRSC_ST_CAUSE_LSB +: 4];
        cause_nxt = cause_nxt | {por_active, lvr_trip, wdt_reset,
                                 !reset_pin_n};
        if (rd_en)
        begin
            if (addr == SRSC_CFG_OFF)
                rdata_nxt = {4'h0, cfg_r};
            else if (addr == SRSC_OPT_OFF)
                rdata_nxt = {4'h0, opt_r};
            else if (addr == SRSC_STATUS_OFF)
                rdata_nxt = {cause_r, state_bits(state_r)};
            else
                rdata_nxt = 8'h00;
        end
    end

    // Option settings survive the internal reset sequence on purpose.
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            cfg_r   <= SRSC_CFG_RST;
            opt_r   <= SRSC_OPT_RST;
            cause_r <= SRSC_CAUSE_RST;
            rdata_r <= 8'h00;
        end
        else
        begin
            cfg_r   <= cfg_nxt;
            opt_r   <= opt_nxt;
            cause_r <= cause_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign rdata = rdata_r;

    // Clock and oscillator gating.
    always_comb
    begin
        sys_reset_n    = (state_r != SRSC_ST_RESET);
        core_run       = (state_r == SRSC_ST_RUN);
        periph_clk_en  = (state_r != SRSC_ST_DSTOP)
                      && (state_r != SRSC_ST_TSTOP);
        bt_clk_en      = periph_clk_en
                      || (state_r == SRSC_ST_TSTOP && bt_on_osc);
        ceramic_osc_en = ceramic_req;
        mrc_osc_en     = mrc_req;
        xtal_osc_en    = xtal_req;
        lsrc_osc_en    = lsrc_wdt_req;
        if (state_r == SRSC_ST_DSTOP)
        begin
            ceramic_osc_en = 1'b0;
            mrc_osc_en     = 1'b0;
            xtal_osc_en    = 1'b0;
        end
        else if (state_r == SRSC_ST_TSTOP)
        begin
            ceramic_osc_en = 1'b0;
            mrc_osc_en     = 1'b0;
            xtal_osc_en    = xtal_hold_r;
            if (bt_src == SRSC_BT_LSRC)
                lsrc_osc_en = lsrc_hold_r;
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);

    sequence seq_wake_start;
        $rose(state_r == SRSC_ST_WAKE);
    endsequence

    sequence seq_wake_done;
        ##[1:210] (core_run || !sys_reset_n);
    endsequence

    AST_POR_ONCE: assert property (
        $fell(por_active) |-> !por_active [*8])
        else $error("power-on reset came back");
    AST_LVR_RESET: assert property (
        lvr_trip |=> !sys_reset_n)
        else $error("low-voltage trip did not reset");
    AST_PAUSE_CORE: assert property (
        state_r == SRSC_ST_PAUSE |-> !core_run && periph_clk_en)
        else $error("pause gating wrong");
    AST_PAUSE_OSC: assert property (
        state_r == SRSC_ST_PAUSE |-> ceramic_osc_en == ceramic_req
            && xtal_osc_en == xtal_req && mrc_osc_en == mrc_req)
        else $error("pause changed an oscillator");
    AST_PAUSE_WAKE: assert property (
        state_r == SRSC_ST_PAUSE && irq_any && !reset_src |=> core_run)
        else $error("pause did not end on interrupt");
    AST_DSTOP_GATE: assert property (
        state_r == SRSC_ST_DSTOP |-> !core_run && !periph_clk_en
            && !bt_clk_en)
        else $error("deep stop left clocks running");
    AST_DSTOP_OSC: assert property (
        state_r == SRSC_ST_DSTOP |-> !ceramic_osc_en && !mrc_osc_en
            && !xtal_osc_en)
        else $error("deep stop left an oscillator on");
    AST_LSRC_WDT: assert property (
        state_r != SRSC_ST_TSTOP |-> lsrc_osc_en == lsrc_wdt_req)
        else $error("low-speed RC not under watchdog control");
    AST_DSTOP_WAKE: assert property (
        state_r == SRSC_ST_DSTOP && wake_deep && !reset_src
            |=> state_r == SRSC_ST_WAKE)
        else $error("deep stop ignored wake source");
    AST_EDGE_NOWAKE: assert property (
        !cfg_r[SRSC_CFG_A_LVL_BIT] && !cfg_r[SRSC_CFG_B_LVL_BIT]
            && !ext_irq_c && !ext_irq_e && !port0_irq |-> !wake_deep)
        else $error("edge-mode input woke the device");
    AST_TSTOP_BT: assert property (
        state_r == SRSC_ST_TSTOP |-> bt_clk_en == bt_on_osc
            && !periph_clk_en)
        else $error("base timer gating wrong");
    AST_TSTOP_OSC: assert property (
        state_r == SRSC_ST_TSTOP |-> !ceramic_osc_en && !mrc_osc_en)
        else $error("timekeeping left an oscillator on");
    AST_XTAL_HOLD: assert property (
        state_r == SRSC_ST_TSTOP && $past(state_r) == SRSC_ST_TSTOP
            |-> $stable(xtal_osc_en))
        else $error("crystal changed during timekeeping");
    AST_LSRC_HOLD: assert property (
        state_r == SRSC_ST_TSTOP && $past(state_r) == SRSC_ST_TSTOP
            && bt_src == SRSC_BT_LSRC && $stable(bt_src)
            |-> $stable(lsrc_osc_en))
        else $error("low-speed RC changed during timekeeping");
    AST_TSTOP_WAKE: assert property (
        state_r == SRSC_ST_TSTOP && bt_irq && !reset_src
            |=> state_r == SRSC_ST_WAKE)
        else $error("base timer did not wake");
    AST_WAKE_RESUME: assert property (
        seq_wake_start |-> seq_wake_done)
        else $error("wake did not resume execution");
    AST_RESET_SEQ: assert property (
        $fell(sys_reset_n) |-> !core_run [*8])
        else $error("reset sequence too short");

endmodule

/* verilog/srsc_pkg.sv */
package srsc_pkg;

    // Register byte offsets.
    localparam logic [7:0] SRSC_CTRL_OFF   = 8'h00;
    localparam logic [7:0] SRSC_CFG_OFF    = 8'h04;
    localparam logic [7:0] SRSC_OPT_OFF    = 8'h08;
    localparam logic [7:0] SRSC_STATUS_OFF = 8'h0C;

    // Standby command codes written to the control register.
    localparam logic [1:0] SRSC_CMD_NONE   = 2'h0;
    localparam logic [1:0] SRSC_CMD_PAUSE  = 2'h1;
    localparam logic [1:0] SRSC_CMD_DSTOP  = 2'h2;
    localparam logic [1:0] SRSC_CMD_TSTOP  = 2'h3;

    // Field positions.
    localparam int SRSC_CTRL_CMD_LSB  = 0;
    localparam int SRSC_CFG_A_LVL_BIT = 0;
    localparam int SRSC_CFG_B_LVL_BIT = 1;
    localparam int SRSC_CFG_BTSRC_LSB = 2;
    localparam int SRSC_OPT_EN_BIT    = 0;
    localparam int SRSC_OPT_LVL_LSB   = 1;
    localparam int SRSC_ST_PAUSE_BIT  = 0;
    localparam int SRSC_ST_DSTOP_BIT  = 1;
    localparam int SRSC_ST_TSTOP_BIT  = 2;
    localparam int SRSC_ST_WAKE_BIT   = 3;
    localparam int SRSC_ST_CAUSE_LSB  = 4;

    // Base timer clock sources.
    localparam logic [1:0] SRSC_BT_XTAL   = 2'h0;
    localparam logic [1:0] SRSC_BT_LSRC   = 2'h1;

    // Reset values and number of threshold levels.
    localparam logic [3:0] SRSC_CFG_RST    = 4'h0;
    localparam logic [3:0] SRSC_OPT_RST    = 4'h0;
    localparam logic [3:0] SRSC_CAUSE_RST  = 4'h0;
    localparam int         SRSC_LVL_COUNT  = 7;

    // Timing.
    localparam int SRSC_CLK_PERIOD_NS = 10;
    localparam int SRSC_POR_HOLD_NS   = 10000;
    localparam int SRSC_RST_HOLD_NS   = 1000;
    localparam int SRSC_WAKE_NS       = 2000;
    localparam int SRSC_POR_CYCLES    =
        (SRSC_POR_HOLD_NS + SRSC_CLK_PERIOD_NS - 1) / SRSC_CLK_PERIOD_NS;
    localparam int SRSC_RST_CYCLES    =
        (SRSC_RST_HOLD_NS + SRSC_CLK_PERIOD_NS - 1) / SRSC_CLK_PERIOD_NS;
    localparam int SRSC_WAKE_CYCLES   =
        (SRSC_WAKE_NS + SRSC_CLK_PERIOD_NS - 1) / SRSC_CLK_PERIOD_NS;
    localparam int SRSC_CNT_W         = 10;

    typedef enum logic [2:0]
    {
        SRSC_ST_RUN,
        SRSC_ST_PAUSE,
        SRSC_ST_DSTOP,
        SRSC_ST_TSTOP,
        SRSC_ST_WAKE,
        SRSC_ST_RESET
    } srsc_state_e;

endpackage

/* verilog/srsc_por.sv */
`timescale 1ns/1ps
module srsc_por
(
    input  wire logic clock,
    input  wire logic rstn,
    output logic      por_active
);
    import srsc_pkg::*;

    logic [SRSC_CNT_W-1:0] cnt_r;
    logic [SRSC_CNT_W-1:0] cnt_nxt;
    logic                  done_r;
    logic                  done_nxt;

    // Power application is the only event that clears the done flag.
    always_comb
    begin
        cnt_nxt  = cnt_r;
        done_nxt = done_r;
        if (!done_r)
        begin
            if (cnt_r == SRSC_CNT_W'(SRSC_POR_CYCLES - 1))
                done_nxt = 1'b1;
            else
                cnt_nxt = cnt_r + SRSC_CNT_W'(1);
        end
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            cnt_r  <= '0;
            done_r <= 1'b0;
        end
        else
        begin
            cnt_r  <= cnt_nxt;
            done_r <= done_nxt;
        end
    end

    assign por_active = !done_r;

endmodule

/* verilog/srsc_wake.sv */
`timescale 1ns/1ps
module srsc_wake
(
    input  wire logic ext_irq_a,
    input  wire logic ext_irq_b,
    input  wire logic ext_irq_c,
    input  wire logic ext_irq_e,
    input  wire logic ext_irq_a_level,
    input  wire logic ext_irq_b_level,
    input  wire logic port0_irq,
    input  wire logic bt_irq,
    output logic      wake_deep,
    output logic      wake_time
);
    import srsc_pkg::*;

    // Edge detectors need a running clock, so inputs a and b wake only in level mode; c, e and port 0 always wake.
    always_comb
    begin
        wake_deep = (ext_irq_a && ext_irq_a_level)
                 || (ext_irq_b && ext_irq_b_level)
                 || ext_irq_c || ext_irq_e
                 || port0_irq;
        wake_time = wake_deep || bt_irq;
    end

endmodule

/* testbench/srsc_far_model.sv */
`timescale 1ns/1ps
module srsc_far_model
(
    input  wire logic       clock,
    input  wire logic       rstn,
    input  wire logic [3:0] osc_want,
    input  wire logic [6:0] irq_want,
    output logic      [3:0] osc_req,
    output logic      [6:0] irq_out
);
    // Oscillator circuits and interrupt sources answer one cycle late.
    // The block must not rely on seeing a request in the edge it is made.
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            osc_req <= 4'hF;
            irq_out <= 7'h00;
        end
        else
        begin
            osc_req <= osc_want;
            irq_out <= irq_want;
        end
    end
endmodule

/* testbench/tb_standby_reset_control.sv */
`timescale 1ns/1ps
module tb_standby_reset_control;
    import srsc_pkg::*;
    logic       clock;
    logic       rstn;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr_en;
    logic       rd_en;
    logic [7:0] rdata;
    logic       reset_pin_n;
    logic       wdt_reset;
    logic [6:0] supply_below;
    logic [3:0] osc_want;
    logic [6:0] irq_want;
    logic [3:0] osc_req;
    logic [6:0] irq_out;
    logic       sys_reset_n;
    logic       core_run;
    logic       periph_clk_en;
    logic       bt_clk_en;
    logic [3:0] osc_en;
    int         num_errors;
    int         n_tests;
    int         seed;
    int         cnt;
    int         lvl;
    logic [7:0] rv;
    logic [3:0] r0;
    logic [3:0] r1;

    srsc_top i_srsc_top
    (
        .clock(clock), .rstn(rstn), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .reset_pin_n(reset_pin_n), .wdt_reset(wdt_reset),
        .supply_below(supply_below), .irq_any(irq_out[6]),
        .ext_irq_a(irq_out[0]), .ext_irq_b(irq_out[1]),
        .ext_irq_c(irq_out[2]), .ext_irq_e(irq_out[3]),
        .port0_irq(irq_out[4]), .bt_irq(irq_out[5]),
        .ceramic_req(osc_req[3]), .mrc_req(osc_req[2]),
        .xtal_req(osc_req[1]), .lsrc_wdt_req(osc_req[0]),
        .sys_reset_n(sys_reset_n), .core_run(core_run),
        .periph_clk_en(periph_clk_en), .bt_clk_en(bt_clk_en),
        .ceramic_osc_en(osc_en[3]), .mrc_osc_en(osc_en[2]),
        .xtal_osc_en(osc_en[1]), .lsrc_osc_en(osc_en[0])
    );

    srsc_far_model i_srsc_far_model
    (
        .clock(clock), .rstn(rstn), .osc_want(osc_want),
        .irq_want(irq_want), .osc_req(osc_req), .irq_out(irq_out)
    );

    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // Mode 0 run, 1 pause, 2 deep stop, 3 timekeeping stop, 4 waking.
    function automatic logic [7:0] exp_out(int m, logic [3:0] req,
                                           logic [3:0] lat, int src);
        logic [2:0] g;
        logic [3:0] o;
        g = 3'h7;
        o = req;
        if (m == 1 || m == 4)
            g = 3'h3;
        if (m == 2)
        begin
            g = 3'h0;
            o = {3'h0, req[0]};
        end
        if (m == 3)
        begin
            g = {2'h0, src < 2};
            o = {2'h0, lat[1], (src == 1) ? lat[0] : req[0]};
        end
        return {g, 1'b0, o};
    endfunction

    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic check(logic [7:0] got, logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic look(int m, logic [3:0] req, logic [3:0] lat, int src);
        #1;
        check({core_run, periph_clk_en, bt_clk_en, 1'b0, osc_en},
              exp_out(m, req, lat, src));
        // Return on an edge so the next stimulus lands on it.
        @(posedge clock);
    endtask

    task automatic ticks(int n);
        repeat (n) @(posedge clock);
    endtask

    task automatic wr(logic [7:0] a, logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clock);
        wr_en <= 1'b0;
        @(posedge clock);
    endtask

    task automatic rd(logic [7:0] a, logic [7:0] e);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        #1;
        check(rdata, e);
        @(posedge clock);
    endtask

    // Every wait is bounded so a stuck state machine ends the run.
    task automatic wait_run(int lim);
        cnt = 0;
        while (core_run !== 1'b1 && cnt < lim)
        begin
            @(posedge clock);
            cnt++;
        end
        if (cnt >= lim)
        begin
            check({7'h0, core_run}, 8'h01);
            test_done();
        end
        @(posedge clock);
    endtask

    initial
    begin
        seed = 95071;
        num_errors = 0;
        n_tests = 0;
        rstn = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        wr_en = 1'b0;
        rd_en = 1'b0;
        reset_pin_n = 1'b1;
        wdt_reset = 1'b0;
        supply_below = 7'h00;
        osc_want = 4'hF;
        irq_want = 7'h00;
        ticks(6);
        rstn <= 1'b1;
        wait_run(1500);
        look(0, osc_want, osc_want, 0);
        rd(SRSC_STATUS_OFF, 8'h80);
        wr(SRSC_STATUS_OFF, 8'hF0);
        rd(SRSC_STATUS_OFF, 8'h00);
        rv = 8'($random(seed));
        wr(SRSC_CFG_OFF, rv);
        rd(SRSC_CFG_OFF, {4'h0, rv[3:0]});
        wr(SRSC_OPT_OFF, ~rv);
        rd(SRSC_OPT_OFF, {4'h0, ~rv[3:0]});
        rd(SRSC_CTRL_OFF, 8'h00);
        wr(SRSC_CTRL_OFF, {6'h0, SRSC_CMD_NONE});
        look(0, osc_want, osc_want, 0);
        rd(8'h10, 8'h00);
        wr(SRSC_OPT_OFF, 8'h00);
        $display("Test registers finished");
        r0 = 4'($random(seed));
        osc_want <= r0;
        ticks(2);
        wr(SRSC_CTRL_OFF, {6'h0, SRSC_CMD_PAUSE});
        look(1, r0, r0, 0);
        rd(SRSC_STATUS_OFF, 8'h01);
        irq_want <= 7'h40;
        wait_run(6);
        irq_want <= 7'h00;
        look(0, r0, r0, 0);
        $display("Test pause finished");
        for (int m = 2; m < 4; m++)
        begin
            for (int s = 0; s < m + 3; s++)
            begin
                r0 = 4'($random(seed));
                osc_want <= r0;
                wr(SRSC_CFG_OFF, {4'h0, 2'(s % 3), 2'h0});
                wr(SRSC_CTRL_OFF, {6'h0, 2'(m)});
                look(m, r0, r0, s % 3);
                rd(SRSC_STATUS_OFF, 8'(8'h01 << (m - 1)));
                irq_want <= (m == 2) ? 7'h63 : 7'h43;
                ticks(20);
                look(m, r0, r0, s % 3);
                irq_want <= 7'h00;
                wr(SRSC_CFG_OFF, {4'h0, 2'(s % 3), 2'h3});
                r1 = ~r0;
                osc_want <= r1;
                ticks(3);
                look(m, r1, r0, s % 3);
                irq_want <= 7'(7'h01 << s);
                ticks(4);
                look(4, r1, r0, s % 3);
                rd(SRSC_STATUS_OFF, 8'h08);
                irq_want <= 7'h00;
                wait_run(300);
                look(0, r1, r1, 0);
            end
        end
        $display("Test stop modes finished");
        for (int k = 0; k < 5; k++)
        begin
            lvl = $unsigned($random(seed)) % 7;
            wr(SRSC_OPT_OFF, {4'h0, (k == 4) ? 3'h7 : 3'(lvl), k != 3});
            wr(SRSC_CTRL_OFF, {6'h0, SRSC_CMD_PAUSE});
            if (k == 0)
                reset_pin_n <= 1'b0;
            if (k == 1)
                wdt_reset <= 1'b1;
            supply_below <= (k == 2) ? 7'(7'h01 << lvl) : 7'h00;
            if (k > 2)
                supply_below <= 7'h7F;
            ticks(3);
            #1;
            check({7'h0, sys_reset_n}, {7'h0, k > 2});
            ticks(5);
            reset_pin_n <= 1'b1;
            wdt_reset <= 1'b0;
            supply_below <= 7'h00;
            if (k < 3)
            begin
                cnt = 0;
                while (sys_reset_n !== 1'b1 && cnt < 200)
                begin
                    @(posedge clock);
                    cnt++;
                end
                check({7'h0, cnt > 95 && cnt < 106}, 8'h01);
            end
            else
            begin
                irq_want <= 7'h40;
                wait_run(10);
                irq_want <= 7'h00;
            end
            wait_run(20);
            rd(SRSC_STATUS_OFF, (k < 3) ? 8'(8'h10 << k) : 8'h00);
            wr(SRSC_STATUS_OFF, 8'hF0);
        end
        $display("Test reset sources finished");
        test_done();
    end
endmodule
